// ===== verilog/nest_irq_pkg.sv
// Constants used by the nested interrupt priority unit; its bench repeats them as literals.
// Assumes a 32-bit AHB-Lite register bus and one 100 MHz system clock.
package nest_irq_pkg;

    // Register byte offsets, one aligned word each
    localparam logic [7:0] OFS_VECTOR_PRIORITY_0 = 8'h00;
    localparam logic [7:0] OFS_VECTOR_PRIORITY_1 = 8'h04;
    localparam logic [7:0] OFS_VECTOR_PRIORITY_2 = 8'h08;
    localparam logic [7:0] OFS_VECTOR_PRIORITY_3 = 8'h0c;
    localparam logic [7:0] OFS_EXTERNAL_SENSE_CONTROL = 8'h10;

    // Values after reset
    localparam logic [7:0] RST_VECTOR_PRIORITY = 8'hff;
    localparam logic [7:0] RST_EXTERNAL_SENSE_CONTROL = 8'h00;
    localparam logic [7:0] PRIO3_FIXED_ONES = 8'hf0;

    // Two-bit level codes, shared by the stored pairs and the current level
    localparam logic [1:0] LEVEL0_CODE = 2'b10;
    localparam logic [1:0] LEVEL1_CODE = 2'b01;
    localparam logic [1:0] LEVEL2_CODE = 2'b00;
    localparam logic [1:0] LEVEL3_CODE = 2'b11;

    // Sense control field positions
    localparam int PORT_B_SENSE_POS = 6;
    localparam int PORT_B_INVERT_POS = 5;
    localparam int PORT_A_F_SENSE_POS = 3;
    localparam int PORT_A_INVERT_POS = 2;
    localparam logic [7:0] SENSE_WRITABLE = 8'hfc;

    // Sense codes before any inversion
    localparam logic [1:0] SENSE_FALL_LOW = 2'b00;
    localparam logic [1:0] SENSE_RISE = 2'b01;
    localparam logic [1:0] SENSE_FALL = 2'b10;
    localparam logic [1:0] SENSE_BOTH = 2'b11;

    // Vector map
    localparam int NUM_SLOTS = 14;
    localparam int EXT_FIRST_SLOT = 2;
    localparam logic [13:0] PERIPH_SLOTS = 14'h3782;
    localparam logic [13:0] HALT_WAKE_SLOTS = 14'h00be;
    localparam logic [13:0] ACTIVE_HALT_WAKE_SLOTS = 14'h0002;
    localparam logic [15:0] SLOT0_VECTOR = 16'hfffa;
    localparam logic [15:0] TRAP_VECTOR = 16'hfffc;
    localparam logic [15:0] RESET_VECTOR = 16'hfffe;

    // Run and low-power modes of the core
    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_WAIT,
        MODE_HALT,
        MODE_ACTIVE_HALT
    } power_mode_e;

endpackage

// ===== verilog/nest_irq_unit.sv
// Nested interrupt priority unit: priority registers, current level,
// external sense logic, pending latches and arbitration.
// Assumes an AHB-Lite master on SYS_CLK, and a core that pulses its
// level-changing instructions and acknowledges the offered vector.
`timescale 1ns/1ps

// Function
// - Four priority bytes, reset to all ones
// - Upper nibble of fourth byte reads ones
// - Writing level-0 code keeps old pair
// - Pair n serves slot n, descending vectors
// - Serviced pair loads into current level
// - Codes: 10 L0, 01 L1, 00 L2, 11 L3
// - Highest software level wins, then slot order
// - Reset and trap force level 3
// - Rewritten pair re-enters only if higher
// - Unmask loads 10, mask loads 11
// - Masked jump on 11, unmasked otherwise
// - Flag pop restores current level
// - Level changes persist until next change
// - Slot order priority; time base wakes active-halt
// - External slots 2-5 wake from halt only
// - Sync serial wakes halt; spurious exits tolerated
// - Four sense groups, four or five modes
// - Sense writes only at level 3
// - Changed sense value clears external pending
// - Port B field codes, inverted by polarity
// - Port B polarity affects low group only
// - Sense register resets zero, low bits zero
// - Port A polarity, shared port A/F field
module nest_irq_unit (
    input wire logic SYS_CLK,
    input wire logic RST,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Interrupt sources
    input wire logic [13:0] PERIPH_REQ,
    input wire logic [3:0] EXT_PA,
    input wire logic [2:0] EXT_PF,
    input wire logic [4:0] EXT_PB,
    // Core instruction pulses
    input wire logic HALT_OP,
    input wire logic ACTIVE_HALT_SEL,
    input wire logic WAIT_FOR_IRQ_OP,
    input wire logic UNMASK_OP,
    input wire logic MASK_OP,
    input wire logic TRAP_OP,
    input wire logic FLAGS_POP_OP,
    input wire logic IRQ_RETURN_OP,
    input wire logic [1:0] POP_LEVEL,
    input wire logic IRQ_ACK,
    // To the core
    output logic IRQ_REQ,
    output logic [3:0] IRQ_SLOT,
    output logic [15:0] IRQ_VECTOR,
    output logic CUR_LEVEL_HI,
    output logic CUR_LEVEL_LO,
    output logic JUMP_IF_MASKED,
    output logic JUMP_IF_UNMASKED,
    output logic LOW_POWER
);

    typedef struct packed {
        logic [31:0] prio;
        logic [7:0] sense;
        logic [1:0] cur;
        logic [13:0] pend;
        nest_irq_pkg::power_mode_e mode;
        logic [11:0] sync1;
        logic [11:0] sync2;
        logic [11:0] sync3;
        logic [11:0] filt;
        logic [3:0] grp_prev;
        logic wr_pend;
        logic rd_pend;
        logic rd_wait;
        logic [7:0] addr;
        logic [31:0] rdata;
        logic req;
        logic [3:0] slot;
        logic [15:0] vector;
    } state_s;

    state_s st_q;
    state_s st_d;

    // Rank of a level code, 0 lowest to 3 masked
    function automatic logic [1:0] level_rank(input logic [1:0] code);
        case (code)
            nest_irq_pkg::LEVEL0_CODE: level_rank = 2'd0;
            nest_irq_pkg::LEVEL1_CODE: level_rank = 2'd1;
            nest_irq_pkg::LEVEL2_CODE: level_rank = 2'd2;
            default: level_rank = 2'd3;
        endcase
    endfunction

    // Event test on a group level; inversion swaps edges and level sense
    function automatic logic sense_hit(input logic [1:0] sel, input logic inv,
                                       input logic now, input logic prev);
        logic n;
        logic p;
        n = now ^ inv;
        p = prev ^ inv;
        case (sel)
            nest_irq_pkg::SENSE_FALL_LOW: sense_hit = ~n;
            nest_irq_pkg::SENSE_RISE: sense_hit = n & ~p;
            nest_irq_pkg::SENSE_FALL: sense_hit = ~n & p;
            nest_irq_pkg::SENSE_BOTH: sense_hit = n ^ p;
            default: sense_hit = 1'b0;
        endcase
    endfunction

    // Register read view
    function automatic logic [31:0] read_reg(input state_s s, input logic [7:0] a);
        case (a)
            nest_irq_pkg::OFS_VECTOR_PRIORITY_0: read_reg = {24'h0, s.prio[7:0]};
            nest_irq_pkg::OFS_VECTOR_PRIORITY_1: read_reg = {24'h0, s.prio[15:8]};
            nest_irq_pkg::OFS_VECTOR_PRIORITY_2: read_reg = {24'h0, s.prio[23:16]};
            nest_irq_pkg::OFS_VECTOR_PRIORITY_3:
                read_reg = {24'h0, s.prio[31:24] | nest_irq_pkg::PRIO3_FIXED_ONES};
            nest_irq_pkg::OFS_EXTERNAL_SENSE_CONTROL: read_reg = {24'h0, s.sense};
            default: read_reg = 32'h0;
        endcase
    endfunction

    logic [11:0] pins;
    assign pins = {EXT_PB, EXT_PF, EXT_PA};

    // Next state of the whole unit
    always_comb begin
        logic [3:0] grp;
        logic [3:0] hit;
        logic [13:0] set;
        logic [13:0] clr;
        logic [13:0] elig;
        logic [1:0] best;
        logic found;
        logic [7:0] wb;
        logic [1:0] np;
        logic [4:0] pos;
        logic [13:0] wake_mask;
        st_d = st_q;
        grp = 4'h0;
        hit = 4'h0;
        set = 14'h0;
        clr = 14'h0;
        elig = 14'h0;
        best = 2'd0;
        found = 1'b0;
        wb = HWDATA[7:0];
        np = 2'b00;
        pos = 5'd0;
        wake_mask = 14'h3fff;

        // Pin filter: three stages, a change counts when stages two and three agree
        st_d.sync1 = pins;
        st_d.sync2 = st_q.sync1;
        st_d.sync3 = st_q.sync2;
        st_d.filt = ((st_q.sync2 ~^ st_q.sync3) & st_q.sync3)
                  | ((st_q.sync2 ^ st_q.sync3) & st_q.filt);

        // Pins of a group are ORed onto one line
        grp[0] = |st_q.filt[3:0];
        grp[1] = |st_q.filt[6:4];
        grp[2] = |st_q.filt[10:7];
        grp[3] = st_q.filt[11];
        st_d.grp_prev = grp;
        hit[0] = sense_hit(st_q.sense[nest_irq_pkg::PORT_A_F_SENSE_POS +: 2],
                           st_q.sense[nest_irq_pkg::PORT_A_INVERT_POS],
                           grp[0], st_q.grp_prev[0]);
        hit[1] = sense_hit(st_q.sense[nest_irq_pkg::PORT_A_F_SENSE_POS +: 2], 1'b0,
                           grp[1], st_q.grp_prev[1]);
        hit[2] = sense_hit(st_q.sense[nest_irq_pkg::PORT_B_SENSE_POS +: 2],
                           st_q.sense[nest_irq_pkg::PORT_B_INVERT_POS],
                           grp[2], st_q.grp_prev[2]);
        hit[3] = sense_hit(st_q.sense[nest_irq_pkg::PORT_B_SENSE_POS +: 2], 1'b0,
                           grp[3], st_q.grp_prev[3]);
        // Four independent groups on slots 2 to 5
        set = (PERIPH_REQ & nest_irq_pkg::PERIPH_SLOTS)
            | {8'h0, hit, 2'b00};

        // A peripheral that drops its flag withdraws its request
        clr = ~PERIPH_REQ & nest_irq_pkg::PERIPH_SLOTS;

        // AHB address phase; reads take one wait state so data is registered
        if (st_q.rd_wait) begin
            st_d.rd_wait = 1'b0;
            st_d.rd_pend = 1'b0;
            st_d.rdata = read_reg(st_q, st_q.addr);
        end
        st_d.wr_pend = 1'b0;
        if (HREADY && !st_q.rd_wait) begin
            st_d.rd_pend = 1'b0;
            if (HSEL && HTRANS[1]) begin
                st_d.addr = HADDR[7:0];
                st_d.wr_pend = HWRITE;
                st_d.rd_pend = ~HWRITE;
                st_d.rd_wait = ~HWRITE;
            end
        end

        // AHB write data phase
        if (st_q.wr_pend) begin
            case (st_q.addr)
                nest_irq_pkg::OFS_VECTOR_PRIORITY_0, nest_irq_pkg::OFS_VECTOR_PRIORITY_1,
                nest_irq_pkg::OFS_VECTOR_PRIORITY_2, nest_irq_pkg::OFS_VECTOR_PRIORITY_3: begin
                    for (int p = 0; p < 4; p++) begin
                        np = wb[2*p +: 2];
                        pos = 5'({st_q.addr[3:2], 3'b000} + 8'(2 * p));
                        // Upper pairs of the fourth byte stay at ones
                        if (np != nest_irq_pkg::LEVEL0_CODE &&
                            !(st_q.addr == nest_irq_pkg::OFS_VECTOR_PRIORITY_3 && p >= 2)) begin
                            st_d.prio[pos +: 2] = np;
                        end
                    end
                end
                nest_irq_pkg::OFS_EXTERNAL_SENSE_CONTROL: begin
                    // Only honoured while interrupts are masked
                    if (st_q.cur == nest_irq_pkg::LEVEL3_CODE) begin
                        st_d.sense = wb & nest_irq_pkg::SENSE_WRITABLE;
                        if ((wb & nest_irq_pkg::SENSE_WRITABLE) != st_q.sense) begin
                            clr[5:2] = 4'hf;
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // Current level: instructions, trap and service; one source per cycle
        if (FLAGS_POP_OP || IRQ_RETURN_OP) begin
            st_d.cur = POP_LEVEL;
        end else if (MASK_OP || TRAP_OP) begin
            st_d.cur = nest_irq_pkg::LEVEL3_CODE;
        end else if (UNMASK_OP) begin
            st_d.cur = nest_irq_pkg::LEVEL0_CODE;
        end else if (HALT_OP) begin
            st_d.cur = nest_irq_pkg::LEVEL0_CODE;
            st_d.mode = ACTIVE_HALT_SEL ? nest_irq_pkg::MODE_ACTIVE_HALT
                                        : nest_irq_pkg::MODE_HALT;
        end else if (WAIT_FOR_IRQ_OP) begin
            st_d.cur = nest_irq_pkg::LEVEL0_CODE;
            st_d.mode = nest_irq_pkg::MODE_WAIT;
        end else if (IRQ_ACK && st_q.req) begin
            st_d.cur = st_q.prio[{st_q.slot, 1'b0} +: 2];
            st_d.mode = nest_irq_pkg::MODE_RUN;
            clr[st_q.slot] = 1'b1;
        end

        // Pending latches; a new request wins over a clear
        st_d.pend = (st_q.pend & ~clr) | set;

        // Only wake-capable sources may end a halt; the serial slave may cause
        // a spurious exit, which the core must simply accept
        case (st_d.mode)
            nest_irq_pkg::MODE_HALT: wake_mask = nest_irq_pkg::HALT_WAKE_SLOTS;
            nest_irq_pkg::MODE_ACTIVE_HALT:
                wake_mask = nest_irq_pkg::ACTIVE_HALT_WAKE_SLOTS;
            default: wake_mask = 14'h3fff;
        endcase

        // Arbitration on next-state values; a rewritten pair is seen at once
        for (int v = 0; v < nest_irq_pkg::NUM_SLOTS; v++) begin
            elig[v] = st_d.pend[v] && wake_mask[v]
                   && level_rank(st_d.prio[2*v +: 2]) > level_rank(st_d.cur);
        end
        st_d.req = 1'b0;
        st_d.slot = 4'h0;
        for (int v = 0; v < nest_irq_pkg::NUM_SLOTS; v++) begin
            // Strict compare keeps the lower slot on a tie
            if (elig[v] && (!found || level_rank(st_d.prio[2*v +: 2]) > best)) begin
                found = 1'b1;
                best = level_rank(st_d.prio[2*v +: 2]);
                st_d.slot = 4'(v);
            end
        end
        st_d.req = found;
        st_d.vector = nest_irq_pkg::SLOT0_VECTOR - 16'({st_d.slot, 1'b0});
    end

    // State register; reset leaves the core at level 3
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            st_q <= '0;
            st_q.prio <= {4{nest_irq_pkg::RST_VECTOR_PRIORITY}};
            st_q.sense <= nest_irq_pkg::RST_EXTERNAL_SENSE_CONTROL;
            st_q.cur <= nest_irq_pkg::LEVEL3_CODE;
            st_q.mode <= nest_irq_pkg::MODE_RUN;
            st_q.vector <= nest_irq_pkg::SLOT0_VECTOR;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs
    assign HRDATA = st_q.rdata;
    assign HREADYOUT = ~st_q.rd_wait;
    assign HRESP = 1'b0;
    assign IRQ_REQ = st_q.req;
    assign IRQ_SLOT = st_q.slot;
    assign IRQ_VECTOR = st_q.vector;
    assign CUR_LEVEL_HI = st_q.cur[1];
    assign CUR_LEVEL_LO = st_q.cur[0];
    assign JUMP_IF_MASKED = (st_q.cur == nest_irq_pkg::LEVEL3_CODE);
    assign JUMP_IF_UNMASKED = (st_q.cur != nest_irq_pkg::LEVEL3_CODE);
    assign LOW_POWER = (st_q.mode != nest_irq_pkg::MODE_RUN);

endmodule

// ===== tb/nest_irq_assertions.sv
// Checker for the nested interrupt priority unit: level loads, offers and vectors.
// Assumes it is bound to the unit and sees only the unit's ports.
`timescale 1ns/1ps
module nest_irq_checker (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic HALT_OP,
    input wire logic WAIT_FOR_IRQ_OP,
    input wire logic UNMASK_OP,
    input wire logic MASK_OP,
    input wire logic TRAP_OP,
    input wire logic FLAGS_POP_OP,
    input wire logic IRQ_RETURN_OP,
    input wire logic [1:0] POP_LEVEL,
    input wire logic IRQ_ACK,
    input wire logic IRQ_REQ,
    input wire logic [3:0] IRQ_SLOT,
    input wire logic [15:0] IRQ_VECTOR,
    input wire logic CUR_LEVEL_HI,
    input wire logic CUR_LEVEL_LO,
    input wire logic JUMP_IF_MASKED,
    input wire logic JUMP_IF_UNMASKED,
    input wire logic LOW_POWER
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    // Instruction groups in the order the unit ranks them
    wire logic [1:0] lvl = {CUR_LEVEL_HI, CUR_LEVEL_LO};
    wire logic pop = FLAGS_POP_OP | IRQ_RETURN_OP;
    wire logic blk = pop | MASK_OP | TRAP_OP;
    wire logic any = blk | UNMASK_OP | HALT_OP | WAIT_FOR_IRQ_OP;
    jump_flags_a: assert property (JUMP_IF_MASKED == &lvl && JUMP_IF_UNMASKED == !(&lvl))
        else $error("jump flags disagree with level");
    pop_level_a: assert property (pop |=> lvl == $past(POP_LEVEL))
        else $error("popped level not restored");
    mask_level_a: assert property ((MASK_OP || TRAP_OP) && !pop |=> lvl == 2'b11)
        else $error("mask or trap did not set level three");
    unmask_level_a: assert property (UNMASK_OP && !blk |=> lvl == 2'b10)
        else $error("unmask did not set level zero");
    sleep_level_a: assert property ((HALT_OP || WAIT_FOR_IRQ_OP) && !blk && !UNMASK_OP
        |=> lvl == 2'b10 && LOW_POWER) else $error("sleep entry did not unmask");
    // Only an instruction or a taken offer may move the level
    level_hold_a: assert property (!any && !(IRQ_ACK && IRQ_REQ) |=> $stable(lvl))
        else $error("level moved without cause");
    ack_load_a: assert property (IRQ_ACK && IRQ_REQ && !any |=> lvl != 2'b11 && !LOW_POWER)
        else $error("taken offer loaded a masked level");
    offer_gate_a: assert property (IRQ_REQ |-> !(&lvl) && IRQ_SLOT inside {[1:5], [7:10], 12, 13})
        else $error("offer made while masked or on an unused slot");
    vector_map_a: assert property (IRQ_VECTOR == 16'hfffa - {11'h000, IRQ_SLOT, 1'b0})
        else $error("vector does not match slot");
endmodule

bind nest_irq_unit nest_irq_checker CHK (
    .SYS_CLK(SYS_CLK), .RST(RST), .HALT_OP(HALT_OP), .WAIT_FOR_IRQ_OP(WAIT_FOR_IRQ_OP),
    .UNMASK_OP(UNMASK_OP), .MASK_OP(MASK_OP), .TRAP_OP(TRAP_OP), .FLAGS_POP_OP(FLAGS_POP_OP),
    .IRQ_RETURN_OP(IRQ_RETURN_OP), .POP_LEVEL(POP_LEVEL), .IRQ_ACK(IRQ_ACK), .IRQ_REQ(IRQ_REQ),
    .IRQ_SLOT(IRQ_SLOT), .IRQ_VECTOR(IRQ_VECTOR), .CUR_LEVEL_HI(CUR_LEVEL_HI),
    .CUR_LEVEL_LO(CUR_LEVEL_LO), .JUMP_IF_MASKED(JUMP_IF_MASKED),
    .JUMP_IF_UNMASKED(JUMP_IF_UNMASKED), .LOW_POWER(LOW_POWER)
);

// ===== tb/core_ack_model.sv
// Core model that takes one offered vector per request from the bench.
// Assumes the offer is a level and the acknowledge a one-cycle pulse.
`timescale 1ns/1ps
module core_ack_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic irq_req,
    input wire logic take,
    input wire logic [3:0] lag,
    output logic irq_ack,
    output logic acked
);
    logic [3:0] cnt_q;
    // Waits lag cycles of a standing offer, so both prompt and slow cores are seen
    always_ff @(posedge sys_clk) begin
        if (rst || !take) begin
            cnt_q <= 4'h0;
            irq_ack <= 1'b0;
            acked <= 1'b0;
        end else if (irq_ack) begin
            irq_ack <= 1'b0;
            acked <= 1'b1;
        end else if (irq_req && !acked) begin
            if (cnt_q == lag) begin
                irq_ack <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end
endmodule

// ===== tb/nested_interrupt_priority_unit_tb_top.sv
// Testbench for the nested interrupt priority unit: registers, level instructions,
// pending latches and arbitration. Assumes the bound checker and the core model.
`timescale 1ns/1ps
module nested_interrupt_priority_unit_tb_top;
    logic SYS_CLK, RST, HSEL, HWRITE, take, HREADYOUT, IRQ_REQ, IRQ_ACK, acked;
    logic CUR_LEVEL_HI, CUR_LEVEL_LO, JUMP_IF_MASKED, JUMP_IF_UNMASKED, LOW_POWER;
    logic [1:0] HTRANS, POP_LEVEL;
    logic [31:0] HADDR, HWDATA, HRDATA;
    logic [3:0] IRQ_SLOT, lag;
    logic [15:0] IRQ_VECTOR;
    logic [13:0] PERIPH_REQ;
    logic [4:0] EXT_PB;
    logic [3:0] EXT_PA;
    logic ahalt, HRESP;
    logic [6:0] ops;
    logic [7:0] q;
    int miscompares, checks, i;
    // Register rows: offset, written byte, byte read back
    logic [7:0] rows [9][3] = '{'{8'h00, 8'h64, 8'h74}, '{8'h04, 8'hcf, 8'hcf},
        '{8'h04, 8'h64, 8'h44}, '{8'h08, 8'h00, 8'h00}, '{8'h08, 8'haa, 8'h00},
        '{8'h0c, 8'h00, 8'hf0}, '{8'h0c, 8'ha5, 8'hf5}, '{8'h10, 8'hff, 8'hfc},
        '{8'h14, 8'h55, 8'h00}};
    // Instruction rows: pulses, popped level, expected level, low power expected
    logic [11:0] opt [8] = '{12'h204, 12'h405, 12'h106, 12'h04a, 12'h086, 12'h020, 12'h805,
        12'h106};

    nest_irq_unit DUT (.SYS_CLK(SYS_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(3'b010), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PERIPH_REQ(PERIPH_REQ), .EXT_PA(EXT_PA),
        .EXT_PF(3'h0), .EXT_PB(EXT_PB), .HALT_OP(ops[6]), .ACTIVE_HALT_SEL(ahalt),
        .WAIT_FOR_IRQ_OP(ops[5]),
        .UNMASK_OP(ops[4]), .MASK_OP(ops[3]), .TRAP_OP(ops[2]), .FLAGS_POP_OP(ops[1]),
        .IRQ_RETURN_OP(ops[0]), .POP_LEVEL(POP_LEVEL), .IRQ_ACK(IRQ_ACK), .IRQ_REQ(IRQ_REQ),
        .IRQ_SLOT(IRQ_SLOT), .IRQ_VECTOR(IRQ_VECTOR), .CUR_LEVEL_HI(CUR_LEVEL_HI),
        .CUR_LEVEL_LO(CUR_LEVEL_LO), .JUMP_IF_MASKED(JUMP_IF_MASKED),
        .JUMP_IF_UNMASKED(JUMP_IF_UNMASKED), .LOW_POWER(LOW_POWER));
    core_ack_model CORE (.sys_clk(SYS_CLK), .rst(RST), .irq_req(IRQ_REQ), .take(take),
        .lag(lag), .irq_ack(IRQ_ACK), .acked(acked));

    initial begin
        SYS_CLK = 1'b0;
        forever #5 SYS_CLK = ~SYS_CLK;
    end

    // Outputs are looked at mid-cycle, where they have settled
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        @(negedge SYS_CLK);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
        @(posedge SYS_CLK);
    endtask

    // Ready is read at the falling edge, so the value seen is the one the next edge samples
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] r);
        logic rdy;
        HSEL <= 1'b1;
        HTRANS <= 2'b10;
        HWRITE <= w;
        HADDR <= {24'h000000, a};
        do begin
            @(negedge SYS_CLK);
            rdy = HREADYOUT;
            @(posedge SYS_CLK);
        end while (!rdy);
        HSEL <= 1'b0;
        HTRANS <= 2'b00;
        HWDATA <= {24'h000000, d};
        do begin
            @(negedge SYS_CLK);
            rdy = HREADYOUT;
            r = HRDATA[7:0];
            @(posedge SYS_CLK);
        end while (!rdy);
    endtask

    task automatic op(input logic [6:0] v, input logic [1:0] p);
        ops <= v;
        POP_LEVEL <= p;
        @(posedge SYS_CLK);
        ops <= 7'h00;
        @(posedge SYS_CLK);
    endtask

    task automatic ack_one(input logic [3:0] l);
        int n;
        take <= 1'b1;
        lag <= l;
        for (n = 0; n < 40 && acked !== 1'b1; n++) @(negedge SYS_CLK);
        @(posedge SYS_CLK);
        take <= 1'b0;
        @(posedge SYS_CLK);
    endtask

    task automatic complete_run();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // A hang is cut short well past the few hundred cycles the tests need
    initial begin
        #200000;
        miscompares++;
        complete_run();
    end

    initial begin
        {RST, HSEL, HWRITE, HTRANS, HADDR, HWDATA, ops, POP_LEVEL} = '1;
        {HSEL, HWRITE, HTRANS, HADDR, HWDATA, ops, POP_LEVEL, PERIPH_REQ, EXT_PB, EXT_PA} = '0;
        ahalt = 1'b0;
        {take, lag, miscompares, checks} = '0;
        repeat (5) @(posedge SYS_CLK);
        RST <= 1'b0;
        @(posedge SYS_CLK);
        for (i = 0; i < 5; i++) begin
            bus(1'b0, 8'(i * 4), 8'h00, q);
            chk(q, (i < 4) ? 8'hff : 8'h00);
        end
        // All rows run at level 3, the only level at which sense writes land
        for (i = 0; i < 9; i++) begin
            bus(1'b1, rows[i][0], rows[i][1], q);
            bus(1'b0, rows[i][0], 8'h00, q);
            chk(q, rows[i][2]);
        end
        // Port B falling only, inverted for the low group: top pin rising is ignored
        bus(1'b1, 8'h10, 8'hb0, q);
        EXT_PB <= 5'h10;
        repeat (8) @(posedge SYS_CLK);
        op(7'h10, 2'b00);
        chk(IRQ_REQ, 1'b0);
        op(7'h08, 2'b00);
        EXT_PB <= 5'h00;
        repeat (8) @(posedge SYS_CLK);
        bus(1'b1, 8'h10, 8'hb4, q);
        op(7'h10, 2'b00);
        chk(IRQ_REQ, 1'b0);
        op(7'h08, 2'b00);
        EXT_PB <= 5'h10;
        repeat (8) @(posedge SYS_CLK);
        EXT_PB <= 5'h00;
        repeat (8) @(posedge SYS_CLK);
        op(7'h10, 2'b00);
        chk({IRQ_REQ, IRQ_SLOT, IRQ_VECTOR}, {1'b1, 4'd5, 16'hfff0});
        ack_one(4'd0);
        chk({IRQ_REQ, CUR_LEVEL_HI, CUR_LEVEL_LO}, 3'b001);
        op(7'h08, 2'b00);
        // Slots 8 and 9 at level 2 beat slot 12 at level 1; lower slot breaks the tie
        PERIPH_REQ <= 14'h1300;
        op(7'h10, 2'b00);
        chk({IRQ_REQ, IRQ_SLOT, IRQ_VECTOR}, {1'b1, 4'd8, 16'hffea});
        ack_one(4'd5);
        chk({IRQ_REQ, CUR_LEVEL_HI, CUR_LEVEL_LO}, 3'b000);
        PERIPH_REQ <= 14'h1200;
        @(posedge SYS_CLK);
        op(7'h01, 2'b10);
        chk({IRQ_REQ, IRQ_SLOT, IRQ_VECTOR}, {1'b1, 4'd9, 16'hffe8});
        ack_one(4'd2);
        bus(1'b1, 8'h08, 8'h04, q);
        chk({IRQ_REQ, CUR_LEVEL_HI, CUR_LEVEL_LO}, 3'b000);
        PERIPH_REQ <= 14'h0000;
        for (i = 0; i < 8; i++) begin
            op(opt[i][11:5], opt[i][4:3]);
            chk({CUR_LEVEL_HI, CUR_LEVEL_LO, JUMP_IF_MASKED, JUMP_IF_UNMASKED},
                {opt[i][2:1], &opt[i][2:1], ~&opt[i][2:1]});
            if (opt[i][0]) begin
                chk(LOW_POWER, 1'b1);
            end
        end
        op(7'h10, 2'b00);
        bus(1'b1, 8'h10, 8'h40, q);
        bus(1'b0, 8'h10, 8'h00, q);
        chk(q, 8'hb4);
        bus(1'b1, 8'h00, 8'h00, q);
        // Port A falling, inverted: a rising pin requests slot 2, allowed out of halt
        EXT_PA <= 4'h1;
        repeat (8) @(posedge SYS_CLK);
        chk({IRQ_REQ, IRQ_SLOT, IRQ_VECTOR}, {1'b1, 4'd2, 16'hfff6});
        // Active-halt leaves only the time base able to wake the core
        ahalt <= 1'b1;
        op(7'h40, 2'b00);
        chk(IRQ_REQ, 1'b0);
        PERIPH_REQ <= 14'h0002;
        repeat (2) @(posedge SYS_CLK);
        chk({IRQ_REQ, IRQ_SLOT, IRQ_VECTOR}, {1'b1, 4'd1, 16'hfff8});
        RST <= 1'b1;
        repeat (3) @(posedge SYS_CLK);
        RST <= 1'b0;
        @(posedge SYS_CLK);
        bus(1'b0, 8'h00, 8'h00, q);
        chk({q, JUMP_IF_MASKED, HRESP}, {8'hff, 1'b1, 1'b0});
        complete_run();
    end
endmodule
